/* File: src/sal_aux_lock_regs.sv */
// AXI4-Lite register bank for aux RF output, ADC clock and lock detect
// Summary of operation
// - Aux source select bit 6 picks divided output at 0, oscillator at 1.
// - Two-bit aux power field at bits 5:4, read-write, default code 3.
// - Aux enable bit 3 turns aux output on; resets to 0.
// - Separate ADC enable input overrides the ADC clock disable bit.
// - Lock count prescale bit scales lock counts by 32 (32 to 256).
// - Lock state readback bit 0, upper bits zero, reset 0x00.
// - Quad register resets 0x60; bits 7:5, 1:0 writable, 4:2 reserved.
// - Aux register resets 0x32; reserved bit 1 writable, default 1.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "sal_regs.svh"
module sal_aux_lock_regs
  import sal_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [9:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [9:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Analog side status and controls
  input  wire logic        lock_detect_in,
  input  wire logic        adc_enable,
  input  wire logic [1:0]  lock_count_select,
  output logic             aux_source_select,
  output logic [1:0]       aux_power_level,
  output logic             aux_output_on,
  output logic             reserved_osc_bit,
  output logic             adc_clk_on,
  output logic             feedback_divider_off,
  output logic [13:0]      lock_count_cycles,
  output logic [1:0]       quad_band_hi,
  output logic [2:0]       quad_band_field,
  output logic [1:0]       quad_bias_field,
  // Interrupt
  output logic             irq
);

  // One byte per register, carried in byte lane 0 only; reads fill
  // the upper 24 bits with zeros
  // Register state
  sal_byte_t   quad_q, quad_d;
  sal_byte_t   aux_q, aux_d;
  sal_byte_t   adclk_q, adclk_d;
  sal_byte_t   lock_q, lock_d;
  sal_byte_t   stat_q, stat_d;
  sal_byte_t   mask_q, mask_d;
  logic        lock_prev_q, lock_prev_d;
  // Write channel state
  sal_wstate_t wst_q, wst_d;
  logic [7:0]  widx_q, widx_d;
  logic        have_aw_q, have_aw_d;
  logic        have_w_q, have_w_d;
  logic [7:0]  wbyte_q, wbyte_d;
  logic        wlane_q, wlane_d;
  logic [1:0]  bresp_q, bresp_d;
  // Read channel state
  logic        rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0]  rresp_q, rresp_d;

  // Decode, event and count helpers
  logic        do_write;
  logic        hit_w;
  logic        hit_r;
  logic [7:0]  ridx;
  logic [7:0]  rbyte;
  logic        lock_rise;
  logic        lock_fall;
  logic [13:0] lock_count_plain;
  logic [13:0] lock_count_scaled;

  // Handshake outputs stay combinational
  assign s_axi_awready = (wst_q != SAL_W_RESP) && !have_aw_q;
  assign s_axi_wready  = (wst_q != SAL_W_RESP) && !have_w_q;
  assign s_axi_bvalid  = (wst_q == SAL_W_RESP);
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // Byte index is word address; each register owns one word
  // The two low address bits are ignored, so any byte address
  // inside a word reaches that word's register
  assign ridx = s_axi_araddr[`SAL_ADDR_HI:`SAL_ADDR_LO];

  // Write decode covers only the mapped words
  // The readback word counts as mapped: a write there answers OKAY
  // and changes nothing, since its contents follow the pin
  always_comb begin
    case (widx_q)
      `SAL_IDX_QUAD, `SAL_IDX_AUX, `SAL_IDX_ADCLK, `SAL_IDX_LOCK,
      `SAL_IDX_IRQ_STAT, `SAL_IDX_IRQ_MASK: hit_w = 1'b1;
      default: hit_w = 1'b0;
    endcase
  end

  // Write address and data may arrive in either order
  always_comb begin
    wst_d     = wst_q;
    widx_d    = widx_q;
    have_aw_d = have_aw_q;
    have_w_d  = have_w_q;
    wbyte_d   = wbyte_q;
    wlane_d   = wlane_q;
    bresp_d   = bresp_q;
    do_write  = 1'b0;
    // Ready drops once a half is held, so a second beat cannot
    // overwrite it before the commit
    if (s_axi_awvalid && s_axi_awready) begin
      widx_d    = s_axi_awaddr[`SAL_ADDR_HI:`SAL_ADDR_LO];
      have_aw_d = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wbyte_d  = s_axi_wdata[`SAL_LANE0_HI:`SAL_LANE0_LO];
      wlane_d  = s_axi_wstrb[0];
      have_w_d = 1'b1;
    end
    // Commit one cycle after both halves are held
    case (wst_q)
      SAL_W_IDLE, SAL_W_HALF: begin
        if (have_aw_q && have_w_q) begin
          do_write  = 1'b1;
          bresp_d   = hit_w ? `SAL_RESP_OKAY : `SAL_RESP_SLVERR;
          have_aw_d = 1'b0;
          have_w_d  = 1'b0;
          wst_d     = SAL_W_RESP;
        end else if (have_aw_d || have_w_d) begin
          // One half so far; wait for its partner
          wst_d = SAL_W_HALF;
        end
      end
      // Response stands until the master takes it
      SAL_W_RESP: begin
        if (s_axi_bready) begin
          wst_d = SAL_W_IDLE;
        end
      end
      default: wst_d = SAL_W_IDLE;
    endcase
  end

  // Lock edges are the interrupt events
  // The previous-level flop resets low, matching the idle pin, so
  // no false edge follows reset
  assign lock_rise = lock_detect_in && !lock_prev_q;
  assign lock_fall = !lock_detect_in && lock_prev_q;

  // Register file next state
  always_comb begin
    quad_d      = quad_q;
    aux_d       = aux_q;
    adclk_d     = adclk_q;
    mask_d      = mask_q;
    stat_d      = stat_q;
    lock_prev_d = lock_detect_in;
    // Live lock readback, one cycle behind the pin
    lock_d      = `SAL_RST_LOCK;
    lock_d[`SAL_BIT_LOCK] = lock_detect_in;
    if (do_write && wlane_q) begin
      case (widx_q)
        `SAL_IDX_QUAD:  quad_d  = wbyte_q & `SAL_WMASK_QUAD;
        `SAL_IDX_AUX:   aux_d   = wbyte_q & `SAL_WMASK_AUX;
        `SAL_IDX_ADCLK: adclk_d = wbyte_q & `SAL_WMASK_ADCLK;
        // Mask shares the status layout
        `SAL_IDX_IRQ_MASK: mask_d = wbyte_q & `SAL_WMASK_IRQ;
        // Write one to clear a sticky event
        `SAL_IDX_IRQ_STAT: stat_d = stat_q & ~wbyte_q;
        default: ;
      endcase
    end
    // Set wins over a same-cycle clear
    stat_d = stat_d | {6'h00, lock_fall, lock_rise};
  end

  // Read decode with zero-filled upper bits
  // The address is decoded live but only used on the accept edge,
  // where the master still holds it
  always_comb begin
    hit_r = 1'b1;
    case (ridx)
      `SAL_IDX_QUAD:     rbyte = quad_q;
      `SAL_IDX_AUX:      rbyte = aux_q;
      `SAL_IDX_ADCLK:    rbyte = adclk_q;
      `SAL_IDX_LOCK:     rbyte = lock_q;
      `SAL_IDX_IRQ_STAT: rbyte = stat_q;
      `SAL_IDX_IRQ_MASK: rbyte = mask_q;
      default: begin
        rbyte = 8'h00;
        hit_r = 1'b0;
      end
    endcase
  end

  // Read channel next state
  // arready is low while rvalid stands, so release and a new accept
  // never fall in the same cycle
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rdata_d  = {24'h000000, rbyte};
      rresp_d  = hit_r ? `SAL_RESP_OKAY : `SAL_RESP_SLVERR;
    end
  end

  // All state registered with synchronous reset
  // Reset is sampled like any input; every register shares this one
  // clock, so no state crosses a domain
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      quad_q      <= `SAL_RST_QUAD;
      aux_q       <= `SAL_RST_AUX;
      adclk_q     <= `SAL_RST_ADCLK;
      lock_q      <= `SAL_RST_LOCK;
      stat_q      <= `SAL_RST_IRQ;
      mask_q      <= `SAL_RST_IRQ;
      lock_prev_q <= 1'b0;
      wst_q       <= SAL_W_IDLE;
      widx_q      <= 8'h00;
      have_aw_q   <= 1'b0;
      have_w_q    <= 1'b0;
      wbyte_q     <= 8'h00;
      wlane_q     <= 1'b0;
      bresp_q     <= `SAL_RESP_OKAY;
      rvalid_q    <= 1'b0;
      rdata_q     <= 32'h00000000;
      rresp_q     <= `SAL_RESP_OKAY;
    end else begin
      quad_q      <= quad_d;
      aux_q       <= aux_d;
      adclk_q     <= adclk_d;
      lock_q      <= lock_d;
      stat_q      <= stat_d;
      mask_q      <= mask_d;
      lock_prev_q <= lock_prev_d;
      wst_q       <= wst_d;
      widx_q      <= widx_d;
      have_aw_q   <= have_aw_d;
      have_w_q    <= have_w_d;
      wbyte_q     <= wbyte_d;
      wlane_q     <= wlane_d;
      bresp_q     <= bresp_d;
      rvalid_q    <= rvalid_d;
      rdata_q     <= rdata_d;
      rresp_q     <= rresp_d;
    end
  end

  assign aux_source_select    = aux_q[`SAL_BIT_SRC];
  assign aux_power_level      = aux_q[`SAL_BIT_PWR_HI:`SAL_BIT_PWR_LO];
  assign aux_output_on        = aux_q[`SAL_BIT_AUX_ON];
  assign reserved_osc_bit     = aux_q[`SAL_BIT_RSV_OSC];
  // ADC enable has precedence
  // Disable bit is kept for readback only; the enable input decides
  assign adc_clk_on           = adc_enable;
  // Divider power-down follows its bit
  assign feedback_divider_off = adclk_q[`SAL_BIT_NDIV_OFF];
  // Lock count scaled by 32
  // Undivided count is 1024 cycles shifted by the select code; the
  // prescale brings it down to 32, 64, 128 or 256 cycles
  assign lock_count_plain  = `SAL_LOCK_BASE << lock_count_select;
  assign lock_count_scaled = lock_count_plain >> `SAL_LOCK_SHIFT;
  assign lock_count_cycles = adclk_q[`SAL_BIT_LOCK_COUNT_PRESCALE] ?
    lock_count_scaled : lock_count_plain;
  // Unused quad fields still reach their ports
  assign quad_band_hi      = quad_q[`SAL_BAND_HI:`SAL_BAND_MID];
  assign quad_band_field   = quad_q[`SAL_BAND_HI:`SAL_BAND_LO];
  assign quad_bias_field   = quad_q[`SAL_BIAS_HI:`SAL_BIAS_LO];
  // Level interrupt from unmasked sticky bits
  assign irq = |(stat_q & mask_q);

endmodule

/* File: src/sal_regs.svh */
// Register offsets, field positions and reset values for the aux/lock bank
`ifndef SAL_REGS_SVH
`define SAL_REGS_SVH
`define SAL_IDX_QUAD      8'h71
`define SAL_IDX_AUX       8'h72
`define SAL_IDX_ADCLK     8'h73
`define SAL_IDX_LOCK      8'h7C
`define SAL_IDX_IRQ_STAT  8'h7D
`define SAL_IDX_IRQ_MASK  8'h7E
`define SAL_RST_QUAD      8'h60
`define SAL_RST_AUX       8'h32
`define SAL_RST_ADCLK     8'h00
`define SAL_RST_LOCK      8'h00
`define SAL_RST_IRQ       8'h00
`define SAL_WMASK_QUAD    8'hE3
`define SAL_WMASK_AUX     8'h7A
`define SAL_WMASK_ADCLK   8'h07
`define SAL_WMASK_IRQ     8'h03
`define SAL_BIT_SRC       6
`define SAL_BIT_PWR_HI    5
`define SAL_BIT_PWR_LO    4
`define SAL_BIT_AUX_ON    3
`define SAL_BIT_ADC_DIS   2
`define SAL_BIT_NDIV_OFF  1
`define SAL_BIT_LOCK_COUNT_PRESCALE    0
`define SAL_BIT_LOCK      0
`define SAL_BIT_RSV_OSC   1
`define SAL_BAND_HI       7
`define SAL_BAND_MID      6
`define SAL_BAND_LO       5
`define SAL_BIAS_HI       1
`define SAL_BIAS_LO       0
`define SAL_ADDR_HI       9
`define SAL_ADDR_LO       2
`define SAL_LANE0_HI      7
`define SAL_LANE0_LO      0
`define SAL_LOCK_BASE     14'h0400
`define SAL_LOCK_SHIFT    5
`define SAL_RESP_OKAY     2'h0
`define SAL_RESP_SLVERR   2'h2
`endif

/* File: src/sal_pkg.sv */
// Types shared by the aux output and lock register bank
package sal_pkg;
  typedef enum logic [2:0] {
    SAL_W_IDLE = 3'h1,
    SAL_W_HALF = 3'h2,
    SAL_W_RESP = 3'h4
  } sal_wstate_t;
  typedef logic [7:0] sal_byte_t;
endpackage

/* File: verification/sal_aux_lock_assertions.sv */
// Port assertions for the aux and lock register bank
`timescale 1ns/1ns
module sal_aux_lock_assertions (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Read channel
  input wire logic [9:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Analog side
  input wire logic        adc_enable,
  input wire logic        adc_clk_on,
  input wire logic [1:0]  lock_count_select,
  input wire logic [13:0] lock_count_cycles,
  input wire logic [2:0]  quad_band_field,
  input wire logic [1:0]  quad_band_hi,
  input wire logic [1:0]  aux_power_level,
  input wire logic        aux_output_on
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Read address taken by the bank
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // Read answers and held data
  read_ans_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read not answered");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  rd_upper_a: assert property (s_axi_rvalid |-> !(|s_axi_rdata[31:8]))
    else $error("upper read bits set");
  lock_zero_a: assert property (
    rd_taken ##0 s_axi_araddr == 10'h1F0 |=> !(|s_axi_rdata[7:1]))
    else $error("lock readback upper bits set");
  // Output decoding, enable input wins over the disable bit
  adc_over_a: assert property (adc_clk_on == adc_enable)
    else $error("adc clock ignores enable");
  ld_scale_a: assert property (
    lock_count_cycles == (14'h0400 << lock_count_select) ||
    lock_count_cycles == (14'h0020 << lock_count_select))
    else $error("lock count out of set");
  band_hi_a: assert property (quad_band_hi == quad_band_field[2:1])
    else $error("band high bits differ");
  rst_vals_a: assert property ($rose(aresetn) |->
    aux_power_level == 2'h3 && !aux_output_on) else $error("aux reset wrong");
endmodule

/* File: verification/sal_aux_lock_regs_bench.sv */
// Self-checking bench for the aux and lock register bank
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
  $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module sal_aux_lock_regs_bench;
  // Stimulus and observed ports
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [9:0]  s_axi_awaddr = 10'h0, s_axi_araddr = 10'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, lock_detect_in = 1'b0;
  logic        adc_enable = 1'b0;
  logic [1:0]  lock_count_select = 2'h0, s_axi_bresp, s_axi_rresp;
  logic [1:0]  aux_power_level, quad_band_hi, quad_bias_field;
  logic [2:0]  quad_band_field;
  logic [13:0] lock_count_cycles;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, aux_source_select, aux_output_on, irq;
  logic        reserved_osc_bit, adc_clk_on, feedback_divider_off;
  int          fails = 0, check_count = 0, cycles = 0;

  sal_aux_lock_regs sal_aux_lock_regs_inst (.*);

  // 100 MHz clock
  always #5 aclk = ~aclk;
  // Hang guard, well above the 120 or so cycles needed
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Write one byte, address and data offered together
  task automatic wr(input logic [9:0] a, input logic [7:0] d,
                    input logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // Each channel drops its valid at its own accept edge
    fork
      begin
        do @(posedge aclk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!s_axi_wready);
        s_axi_wvalid <= 1'b0;
      end
    join
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, r)
  endtask
  // Read one byte; ready comes late so the data must stand
  task automatic rd(input logic [9:0] a, input logic [7:0] e,
                    input logic [1:0] r = 2'h0);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rdata, {24'h0, e})
    `CHK(s_axi_rresp, r)
  endtask

  task automatic t_reset();
    rd(10'h1C4, 8'h60);
    rd(10'h1C8, 8'h32);
    rd(10'h1F0, 8'h00);
    `CHK(reserved_osc_bit, 1'b1)
    `CHK(aux_output_on, 1'b0)
    `CHK(aux_power_level, 2'h3)
    `CHK(quad_band_field, 3'h3)
  endtask
  // All power codes, reserved bits written as ones
  task automatic t_aux();
    for (int i = 0; i < 8; i++) begin
      wr(10'h1C8, {1'b1, i[0], i[2:1], ~i[0], 3'h7}, 2'h0);
      rd(10'h1C8, {1'b0, i[0], i[2:1], ~i[0], 3'h2});
      `CHK(aux_source_select, i[0])
      `CHK(aux_power_level, i[2:1])
      `CHK(aux_output_on, ~i[0])
    end
  endtask
  // Quad fields, lane 0 strobe off, unmapped write
  task automatic t_quad();
    wr(10'h1C4, 8'hFF, 2'h0);
    rd(10'h1C4, 8'hE3);
    `CHK(quad_bias_field, 2'h3)
    `CHK(quad_band_field, 3'h7)
    wr(10'h1C8, 8'h00, 2'h0);
    `CHK(reserved_osc_bit, 1'b0)
    s_axi_wstrb <= 4'h0;
    wr(10'h1C4, 8'h00, 2'h0);
    s_axi_wstrb <= 4'h1;
    rd(10'h1C4, 8'hE3);
    wr(10'h100, 8'hFF, 2'h2);
    rd(10'h100, 8'h00, 2'h2);
  endtask
  // Prescaled and plain lock counts, enable over disable bit
  task automatic t_adc_lock();
    wr(10'h1CC, 8'hFF, 2'h0);
    rd(10'h1CC, 8'h07);
    `CHK(feedback_divider_off, 1'b1)
    for (int i = 0; i < 4; i++) begin
      lock_count_select <= i[1:0];
      adc_enable <= i[0];
      @(posedge aclk);
      `CHK(lock_count_cycles, 14'h0020 << i)
      `CHK(adc_clk_on, i[0])
    end
    wr(10'h1CC, 8'h00, 2'h0);
    `CHK(lock_count_cycles, 14'h2000)
    `CHK(feedback_divider_off, 1'b0)
  endtask
  // Lock readback, sticky events, mask and clear
  task automatic t_lock();
    wr(10'h1F8, 8'h03, 2'h0);
    lock_detect_in <= 1'b1;
    repeat (3) @(posedge aclk);
    wr(10'h1F0, 8'h00, 2'h0);
    rd(10'h1F0, 8'h01);
    rd(10'h1F4, 8'h01);
    `CHK(irq, 1'b1)
    wr(10'h1F4, 8'h01, 2'h0);
    `CHK(irq, 1'b0)
    lock_detect_in <= 1'b0;
    repeat (3) @(posedge aclk);
    `CHK(irq, 1'b1)
    wr(10'h1F8, 8'h00, 2'h0);
    `CHK(irq, 1'b0)
    rd(10'h1F4, 8'h02);
  endtask

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_aux();
    t_quad();
    t_adc_lock();
    t_lock();
    finish_test();
  end
endmodule
bind sal_aux_lock_regs sal_aux_lock_assertions sal_aux_lock_assertions_inst (.*);
